// *** common/dadc_cfg.svh ***
// offsets, reset values and timing counts of the dual converter output control
`ifndef DADC_CFG_SVH
`define DADC_CFG_SVH

// converter word width
`define DADC_W            12
// system clock period in picoseconds (125 MHz)
`define DADC_CLK_PS       32'd8000
// reference recharge time after sleep, in microseconds
`define DADC_SLEEP_WAKE_US 32'd1000
// least wait in system clocks, rounded up
`define DADC_SLEEP_WAKE_CYC \
	((`DADC_SLEEP_WAKE_US * 32'd1000000 + `DADC_CLK_PS - 32'd1) / `DADC_CLK_PS)
// sample clock edges until data is valid after nap
`define DADC_NAP_WAKE_EDGES 8'h64
// sample clock edges the stabilizer needs to lock after reset
`define DADC_LOCK_EDGES   7'h64
// system clocks without a sample edge before lock is lost
`define DADC_STOP_CYC     16'h0400

// levels of the four-level configuration pin
`define DADC_MODE_GND     2'h0
`define DADC_MODE_THIRD   2'h1
`define DADC_MODE_TWO3    2'h2
`define DADC_MODE_VDD     2'h3

// register offsets
`define DADC_REG_STATUS   8'h00
`define DADC_REG_SLEEP    8'h04
`define DADC_REG_NAP      8'h08

// status field positions
`define DADC_ST_PWR_A     0
`define DADC_ST_LOCK_A    3
`define DADC_ST_VALID_A   4
`define DADC_ST_PWR_B     5
`define DADC_ST_LOCK_B    8
`define DADC_ST_VALID_B   9

`endif

// *** common/dadc_pkg.sv ***
// types shared by the dual converter output control
package dadc_pkg;

	// power state of one channel
	typedef enum logic [2:0] {
		PWR_RUN,
		PWR_NAP,
		PWR_SLEEP,
		PWR_NAP_EXIT,
		PWR_SLEEP_EXIT
	} dadc_pwr_t;

	// state of one channel
	typedef struct packed {
		dadc_pwr_t   pwr;       // power state
		logic [31:0] wait_cnt;  // recovery countdown
		logic        clk_prev;  // sample clock last cycle
		logic [11:0] pipe_word; // captured, formatted word
		logic        pipe_over; // captured overrange
		logic        pipe_ok;   // capture made while running
		logic        two_comp;  // format of captured word
		logic        stab;      // stabilizer state at capture
		logic [11:0] word;      // presented word
		logic        over;      // presented overrange
		logic        valid;     // presented word is good
	} dadc_chan_t;

	// whole state of the top module
	typedef struct packed {
		dadc_chan_t [1:0] ch;
		logic [11:0]      word_first;
		logic [11:0]      word_second;
		logic             of_first;
		logic             of_second;
		logic             oe_first;
		logic             oe_second;
	} dadc_top_t;

	// state of the stabilizer lock tracker
	typedef struct packed {
		logic [15:0] cnt;    // system clocks since last rise
		logic [15:0] period; // last measured period
		logic [6:0]  edges;  // rises seen since lock loss
		logic        locked; // lock reached
		logic        mid;    // internal falling edge pulse
	} dadc_lock_t;

	// state of the register file
	typedef struct packed {
		logic [31:0] sleep_wake;
		logic [7:0]  nap_wake;
		logic [31:0] rdata;
	} dadc_regs_t;

endpackage : dadc_pkg

// *** src/dadc_lock.sv ***
// duty cycle stabilizer model: lock tracking and internal falling edge
`timescale 1ns/1ps
`default_nettype none
`include "dadc_cfg.svh"

module dadc_lock (
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic rise,      // rising sample clock edge, one cycle
	output logic      locked_q,  // stabilizer locked
	output logic      mid_q      // internal falling edge, one cycle
);
	dadc_pkg::dadc_lock_t q;
	dadc_pkg::dadc_lock_t d;

	// period measurement, stop detection and edge counting
	always_comb begin
		d = q;
		d.mid = 1'b0;
		if (rise) begin
			d.period = q.cnt;
			d.cnt = 16'h0001;
			if (q.edges != `DADC_LOCK_EDGES) begin
				d.edges = q.edges + 7'h01;
			end
		end else begin
			if (q.cnt != 16'hffff) begin
				d.cnt = q.cnt + 16'h0001;
			end
			// half the period after the rise: internal falling edge
			if (q.period != 16'h0000 && q.cnt == {1'b0, q.period[15:1]}) begin
				d.mid = 1'b1;
			end
		end
		// clock stopped too long: relock from scratch
		if (q.cnt >= `DADC_STOP_CYC) begin
			d.edges = 7'h00;
			d.period = 16'h0000;
		end
		d.locked = (d.edges == `DADC_LOCK_EDGES);
	end

	// state register
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign locked_q = q.locked;
	assign mid_q    = q.mid;

	default clocking lcb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// the hundredth rise completes the lock
	lock_after_edges_a: assert property (
		rise && q.edges == 7'h63 && q.cnt < `DADC_STOP_CYC |=> locked_q)
		else $error("stabilizer did not lock on the hundredth edge");

	// a long stop drops the lock
	stop_drops_lock_a: assert property (
		q.cnt >= `DADC_STOP_CYC && !rise |=> !locked_q)
		else $error("lock kept after a long clock stop");

endmodule : dadc_lock
`default_nettype wire

// *** src/dadc_regs.sv ***
// register file: recovery waits and status readback
`timescale 1ns/1ps
`default_nettype none
`include "dadc_cfg.svh"

module dadc_regs #(
	parameter logic [31:0] SLEEP_RST = `DADC_SLEEP_WAKE_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [9:0]  status,
	output logic [31:0]      reg_rdata,
	output logic [31:0]      sleep_wake_q,
	output logic [7:0]       nap_wake_q
);
	dadc_pkg::dadc_regs_t q;
	dadc_pkg::dadc_regs_t d;

	// decode writes and reads; unmapped reads return zero
	always_comb begin
		d = q;
		d.rdata = 32'h0000_0000;
		if (reg_wr) begin
			unique case (reg_addr)
				`DADC_REG_SLEEP: d.sleep_wake = reg_wdata;
				`DADC_REG_NAP:   d.nap_wake = reg_wdata[7:0];
				default:         d.rdata = 32'h0000_0000;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				`DADC_REG_STATUS: d.rdata = {22'h00_0000, status};
				`DADC_REG_SLEEP:  d.rdata = q.sleep_wake;
				`DADC_REG_NAP:    d.rdata = {24'h00_0000, q.nap_wake};
				default:          d.rdata = 32'h0000_0000;
			endcase
		end
	end

	// state register
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			q.sleep_wake <= SLEEP_RST;
			q.nap_wake   <= `DADC_NAP_WAKE_EDGES;
			q.rdata      <= 32'h0000_0000;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata    = q.rdata;
	assign sleep_wake_q = q.sleep_wake;
	assign nap_wake_q   = q.nap_wake;

endmodule : dadc_regs
`default_nettype wire

// *** src/dadc_out_ctrl.sv ***
// dual converter output control: format, power states, enables, bus swap
`timescale 1ns/1ps
`default_nettype none
`include "dadc_cfg.svh"

// Summary of operation
// - ground: binary, stabilizer off; third: binary, on
// - two thirds: twos complement on; supply: off
// - one mode pin sets both channels
// - overrange flag high when input out of range
// - enable high floats channel data and flag
// - separate enable per channel
// - shutdown low converts normally
// - shutdown and enable high: sleep, long recovery
// - shutdown high, enable low: nap, 100 cycles
// - sleep and nap float all channel outputs
// - channel power states fully independent
// - swap high: A on first bus, B second
// - swap low: buses exchanged
// - stabilizer: rising sample, internal mid falling edge
// - stabilizer relocks on the 101st edge after a stop
module dadc_out_ctrl #(
	parameter logic [31:0] SLEEP_WAKE_CYC = `DADC_SLEEP_WAKE_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic [1:0]  mode_level,                  // four-level pin, 0..3
	input  wire logic        sample_clk_first,            // channel A sample clock
	input  wire logic        sample_clk_second,           // channel B sample clock
	input  wire logic [11:0] core_word_first,             // A conversion, offset binary
	input  wire logic        core_over_first,             // A input out of range
	input  wire logic [11:0] core_word_second,            // B conversion, offset binary
	input  wire logic        core_over_second,            // B input out of range
	input  wire logic        power_down_chan_first,
	input  wire logic        power_down_chan_second,
	input  wire logic        output_enable_n_chan_first,
	input  wire logic        output_enable_n_chan_second,
	input  wire logic        bus_swap_sel,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	output logic [11:0]      data_bus_first,
	output logic             overrange_flag_bus_first,
	output logic             bus_first_oe,                // drives word and flag
	output logic [11:0]      data_bus_second,
	output logic             overrange_flag_bus_second,
	output logic             bus_second_oe
);
	dadc_pkg::dadc_top_t q;           // registered state
	dadc_pkg::dadc_top_t d;           // next state
	logic [1:0]          sclk;        // sample clocks, index 0 is A
	logic [1:0]          pd;          // shutdown inputs
	logic [1:0]          oen;         // active-low enables
	logic [11:0]         core_w [2];  // core words
	logic [1:0]          core_o;      // core overrange
	logic [1:0]          rise;        // rising sample edge this cycle
	logic [1:0]          locked;      // stabilizer lock per channel
	logic [1:0]          mid;         // internal falling edge per channel
	logic [1:0]          drive;       // channel may drive its bus
	logic [31:0]         sleep_wake;  // wait after sleep, system clocks
	logic [7:0]          nap_wake;    // wait after nap, sample edges
	logic [9:0]          status;      // status word for readback

	// mode pin: twos complement at the upper two levels
	function automatic logic mode_tc(input logic [1:0] m);
		return (m == `DADC_MODE_TWO3) || (m == `DADC_MODE_VDD);
	endfunction : mode_tc

	// mode pin: stabilizer on at the two middle levels
	function automatic logic mode_stab(input logic [1:0] m);
		return (m == `DADC_MODE_THIRD) || (m == `DADC_MODE_TWO3);
	endfunction : mode_stab

	// channel powered enough to drive pins
	function automatic logic awake(input dadc_pkg::dadc_pwr_t p);
		return (p != dadc_pkg::PWR_NAP) && (p != dadc_pkg::PWR_SLEEP);
	endfunction : awake

	assign sclk   = {sample_clk_second, sample_clk_first};
	assign pd     = {power_down_chan_second, power_down_chan_first};
	assign oen    = {output_enable_n_chan_second, output_enable_n_chan_first};
	assign core_w[0] = core_word_first;
	assign core_w[1] = core_word_second;
	assign core_o = {core_over_second, core_over_first};

	// edge detect and drive permission per channel
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			rise[i]  = sclk[i] & ~q.ch[i].clk_prev;
			drive[i] = ~oen[i] & awake(q.ch[i].pwr);
		end
	end

	// one stabilizer per channel, each on its own sample clock
	dadc_lock u_lock_first (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.rise     (rise[0]),
		.locked_q (locked[0]),
		.mid_q    (mid[0])
	);

	dadc_lock u_lock_second (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.rise     (rise[1]),
		.locked_q (locked[1]),
		.mid_q    (mid[1])
	);

	assign status = {q.ch[1].valid, locked[1], q.ch[1].pwr,
	                 q.ch[0].valid, locked[0], q.ch[0].pwr};

	// software sees power states; software sets the recovery waits
	dadc_regs #(
		.SLEEP_RST (SLEEP_WAKE_CYC)
	) u_regs (
		.sys_clk      (sys_clk),
		.resetn       (resetn),
		.reg_addr     (reg_addr),
		.reg_wdata    (reg_wdata),
		.reg_wr       (reg_wr),
		.reg_rd       (reg_rd),
		.status       (status),
		.reg_rdata    (reg_rdata),
		.sleep_wake_q (sleep_wake),
		.nap_wake_q   (nap_wake)
	);

	// channel power, capture and presentation, then the bus swap
	always_comb begin
		logic present;
		logic fall;
		present = 1'b0;
		fall = 1'b0;
		d = q;
		for (int i = 0; i < 2; i++) begin
			fall = ~sclk[i] & q.ch[i].clk_prev;
			d.ch[i].clk_prev = sclk[i];
			// each channel looks only at its own shutdown and enable
			unique case (q.ch[i].pwr)
				dadc_pkg::PWR_RUN: begin
					if (pd[i]) begin
						// enable picks sleep or nap
						d.ch[i].pwr = oen[i] ? dadc_pkg::PWR_SLEEP : dadc_pkg::PWR_NAP;
					end
				end
				dadc_pkg::PWR_NAP: begin
					if (pd[i] && oen[i]) begin
						d.ch[i].pwr = dadc_pkg::PWR_SLEEP;
					end else if (!pd[i]) begin
						d.ch[i].pwr = dadc_pkg::PWR_NAP_EXIT;
						d.ch[i].wait_cnt = {24'h00_0000, nap_wake};
					end
				end
				dadc_pkg::PWR_SLEEP: begin
					// reference is off, so stay asleep until shutdown drops
					if (!pd[i]) begin
						d.ch[i].pwr = dadc_pkg::PWR_SLEEP_EXIT;
						d.ch[i].wait_cnt = sleep_wake;
					end
				end
				dadc_pkg::PWR_NAP_EXIT: begin
					if (pd[i]) begin
						d.ch[i].pwr = oen[i] ? dadc_pkg::PWR_SLEEP : dadc_pkg::PWR_NAP;
					end else if (rise[i]) begin
						// nap recovery counts sample clock edges
						if (q.ch[i].wait_cnt <= 32'h0000_0001) begin
							d.ch[i].pwr = dadc_pkg::PWR_RUN;
						end else begin
							d.ch[i].wait_cnt = q.ch[i].wait_cnt - 32'h0000_0001;
						end
					end
				end
				dadc_pkg::PWR_SLEEP_EXIT: begin
					if (pd[i]) begin
						// reference not yet recharged: back to sleep
						d.ch[i].pwr = dadc_pkg::PWR_SLEEP;
					end else if (q.ch[i].wait_cnt <= 32'h0000_0001) begin
						d.ch[i].pwr = dadc_pkg::PWR_RUN;
					end else begin
						d.ch[i].wait_cnt = q.ch[i].wait_cnt - 32'h0000_0001;
					end
				end
				default: begin
					d.ch[i].pwr = dadc_pkg::PWR_SLEEP;
				end
			endcase
			// capture on the rising edge; mode is frozen with the word
			if (rise[i] && awake(q.ch[i].pwr)) begin
				d.ch[i].two_comp  = mode_tc(mode_level);
				d.ch[i].stab      = mode_stab(mode_level);
				// twos complement is offset binary with the top bit inverted
				d.ch[i].pipe_word = core_w[i] ^ {mode_tc(mode_level), 11'h000};
				d.ch[i].pipe_over = core_o[i];
				d.ch[i].pipe_ok   = (q.ch[i].pwr == dadc_pkg::PWR_RUN);
			end
			// present on the falling edge: internal with stabilizer, else external
			present = q.ch[i].stab ? mid[i] : fall;
			if (present && awake(q.ch[i].pwr)) begin
				d.ch[i].word  = q.ch[i].pipe_word;
				d.ch[i].over  = q.ch[i].pipe_over;
				d.ch[i].valid = q.ch[i].pipe_ok & (~q.ch[i].stab | locked[i]);
			end
			if (!awake(q.ch[i].pwr)) begin
				d.ch[i].valid = 1'b0;
			end
		end
		// swap high: A on first bus; swap low: buses exchanged
		if (bus_swap_sel) begin
			d.word_first  = q.ch[0].word;
			d.of_first    = q.ch[0].over;
			d.oe_first    = drive[0];
			d.word_second = q.ch[1].word;
			d.of_second   = q.ch[1].over;
			d.oe_second   = drive[1];
		end else begin
			d.word_first  = q.ch[1].word;
			d.of_first    = q.ch[1].over;
			d.oe_first    = drive[1];
			d.word_second = q.ch[0].word;
			d.of_second   = q.ch[0].over;
			d.oe_second   = drive[0];
		end
	end

	// state register; channels start in run with pins floating
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// every bus output comes straight from the state register
	assign data_bus_first            = q.word_first;
	assign overrange_flag_bus_first  = q.of_first;
	assign bus_first_oe              = q.oe_first;
	assign data_bus_second           = q.word_second;
	assign overrange_flag_bus_second = q.of_second;
	assign bus_second_oe             = q.oe_second;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// leaving nap: exit state, loaded with the programmed edge count
	sequence nap_leave_s;
		q.ch[0].pwr == dadc_pkg::PWR_NAP && !pd[0];
	endsequence

	sequence exit_started_s;
		q.ch[0].pwr == dadc_pkg::PWR_NAP_EXIT;
	endsequence

	fmt_binary_low_a: assert property (
		rise[0] && awake(q.ch[0].pwr) && mode_level == `DADC_MODE_THIRD
		|=> !q.ch[0].two_comp && q.ch[0].stab &&
		    q.ch[0].pipe_word == $past(core_word_first))
		else $error("third level did not give binary with stabilizer");

	fmt_twos_high_a: assert property (
		rise[0] && awake(q.ch[0].pwr) && mode_level == `DADC_MODE_VDD
		|=> q.ch[0].two_comp && !q.ch[0].stab &&
		    q.ch[0].pipe_word[11] != $past(core_word_first[11]))
		else $error("supply level did not give twos complement");

	fmt_shared_a: assert property (
		rise[0] && rise[1] && awake(q.ch[0].pwr) && awake(q.ch[1].pwr)
		|=> q.ch[0].two_comp == q.ch[1].two_comp && q.ch[0].stab == q.ch[1].stab)
		else $error("channels captured different formats");

	over_capture_a: assert property (
		rise[1] && awake(q.ch[1].pwr) |=> q.ch[1].pipe_over == $past(core_over_second))
		else $error("overrange not captured with its word");

	enable_floats_a: assert property (
		output_enable_n_chan_first && bus_swap_sel |=> !bus_first_oe)
		else $error("disabled channel still drives its bus");

	sleep_entry_a: assert property (
		(q.ch[0].pwr == dadc_pkg::PWR_RUN || q.ch[0].pwr == dadc_pkg::PWR_NAP) && pd[0] && oen[0]
		|=> q.ch[0].pwr == dadc_pkg::PWR_SLEEP ##1 !bus_first_oe || !bus_swap_sel)
		else $error("sleep not entered with enable high");

	nap_exit_a: assert property (
		nap_leave_s |=> exit_started_s and q.ch[0].wait_cnt == {24'h00_0000, $past(nap_wake)})
		else $error("nap exit did not load the edge count");

	sleep_float_a: assert property (
		!awake(q.ch[0].pwr) && bus_swap_sel |=> !bus_first_oe)
		else $error("sleeping channel drives the bus");

	chan_indep_a: assert property (
		q.ch[1].pwr == dadc_pkg::PWR_RUN && !pd[1] |=> q.ch[1].pwr == dadc_pkg::PWR_RUN)
		else $error("channel power changed by the other channel");

	swap_high_a: assert property (
		bus_swap_sel |=> data_bus_first == $past(q.ch[0].word) &&
		                 overrange_flag_bus_first == $past(q.ch[0].over))
		else $error("swap high did not put A on the first bus");

	swap_low_a: assert property (
		!bus_swap_sel |=> data_bus_second == $past(q.ch[0].word) &&
		                  overrange_flag_bus_second == $past(q.ch[0].over))
		else $error("swap low did not put A on the second bus");

	word_hold_a: assert property (
		!(q.ch[0].stab ? mid[0] : (~sclk[0] & q.ch[0].clk_prev))
		|=> $stable(q.ch[0].word))
		else $error("word changed outside its presentation edge");

endmodule : dadc_out_ctrl
`default_nettype wire

// *** test/dadc_capture.sv ***
// downstream capture model: the wire level that a latch on one output bus sees
`timescale 1ns/1ps
`default_nettype none

module dadc_capture (
	input  wire logic        sys_clk,
	input  wire logic [11:0] word,    // bus word from the converter
	input  wire logic        flag,    // bus overrange flag
	input  wire logic        oe,      // converter drives the bus
	output logic      [12:0] lvl      // level seen on the wire
);
	logic [12:0] last_q;              // last driven value

	// remember what was last driven, so a released bus can show its inverse
	always_ff @(posedge sys_clk) begin
		if (oe) begin
			last_q <= {flag, word};
		end
	end

	// either bus may be read; a floating bus never repeats a stale match
	assign lvl = oe ? {flag, word} : ~last_q;
endmodule : dadc_capture

`default_nettype wire

// *** test/dadc_out_ctrl_test.sv ***
// self-checking bench of the dual converter output control
`timescale 1ns/1ps
`default_nettype none

module dadc_out_ctrl_test;
	logic        sys_clk, resetn, bus_swap_sel;
	logic [1:0]  mode_level;
	logic        sample_clk_first, sample_clk_second;
	logic [11:0] core_word_first, core_word_second;
	logic        core_over_first, core_over_second;
	logic        power_down_chan_first, power_down_chan_second;
	logic        output_enable_n_chan_first, output_enable_n_chan_second;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, seed;
	logic        reg_wr, reg_rd;
	logic [11:0] data_bus_first, data_bus_second;
	logic        overrange_flag_bus_first, overrange_flag_bus_second;
	logic        bus_first_oe, bus_second_oe;
	logic [12:0] lvl1, lvl2;          // wire levels at the two latches
	logic [27:0] exp_q[$];            // expected bus pair, one per sample period
	int          fail_count, num_checks;

	// short sleep recovery keeps the run brief
	dadc_out_ctrl #(.SLEEP_WAKE_CYC(32'd50)) dadc_out_ctrl_inst (
		.sys_clk, .resetn, .mode_level, .sample_clk_first, .sample_clk_second,
		.core_word_first, .core_over_first, .core_word_second, .core_over_second,
		.power_down_chan_first, .power_down_chan_second, .output_enable_n_chan_first,
		.output_enable_n_chan_second, .bus_swap_sel, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .data_bus_first, .overrange_flag_bus_first, .bus_first_oe,
		.data_bus_second, .overrange_flag_bus_second, .bus_second_oe);
	dadc_capture cap_first (.sys_clk, .word(data_bus_first),
		.flag(overrange_flag_bus_first), .oe(bus_first_oe), .lvl(lvl1));
	dadc_capture cap_second (.sys_clk, .word(data_bus_second),
		.flag(overrange_flag_bus_second), .oe(bus_second_oe), .lvl(lvl2));

	// 125 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// xorshift source of words and flags
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// two's complement is offset binary with the top bit inverted
	function automatic int fmt(int w, int m);
		return (m >= 2) ? (w ^ 'h800) : w;
	endfunction : fmt

	task end_of_test();
		if (fail_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	// both buses: {oe, flag, word} first then second
	task chk_bus(input logic [27:0] e);
		num_checks++;
		if ({bus_first_oe, lvl1, bus_second_oe, lvl2} !== e) begin
			fail_count++;
			$display("[FAIL] %0t bus %h exp %h", $time, {lvl1, lvl2}, e);
		end
	endtask : chk_bus

	task chk_oe(input logic [1:0] e);
		num_checks++;
		if ({bus_first_oe, bus_second_oe} !== e) begin
			fail_count++;
			$display("[FAIL] %0t enables exp %b", $time, e);
		end
	endtask : chk_oe

	// one read, masked compare of the answer in the following cycle
	task chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		num_checks++;
		if ((reg_rdata & m) !== e) begin
			fail_count++;
			$display("[FAIL] %0t read %h got %h", $time, a, reg_rdata);
		end
	endtask : chk_reg

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// one sample period, high two cycles; mode switches to nm after the capture
	// ilv ties the swap select to both sample clocks, as for one shared bus
	task automatic sample(input int nm, input bit chk, input bit ilv = 1'b0);
		logic [31:0] r;
		logic [12:0] a, b;
		logic [27:0] e;
		int          m;
		// read swap and mode at the edge, so a swap set just before has landed
		@(posedge sys_clk);
		r = xs();
		m = mode_level;
		a = 13'(fmt(r[11:0], m)) | {r[12], 12'h000};
		b = 13'(fmt(r[27:16], m)) | {r[28], 12'h000};
		// checks fall in the low half, where an interleaved swap is low
		e = (bus_swap_sel && !ilv) ? {1'b1, a, 1'b1, b} : {1'b1, b, 1'b1, a};
		exp_q.push_back(e);
		{core_over_first, core_word_first} <= r[12:0];
		{core_over_second, core_word_second} <= r[28:16];
		sample_clk_first <= 1'b1;
		sample_clk_second <= 1'b1; // one source for both clocks
		if (ilv) bus_swap_sel <= 1'b1;
		@(posedge sys_clk);
		mode_level <= nm[1:0];
		@(posedge sys_clk);
		sample_clk_first <= 1'b0;
		sample_clk_second <= 1'b0;
		if (ilv) bus_swap_sel <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		// external fall presents at once, stabilizer waits for its own mid point
		if (chk) chk_bus((m == 1 || m == 2) ? exp_q[$-1] : e);
		repeat (6) @(posedge sys_clk);
		#1;
		if (chk) chk_bus(e);
	endtask : sample

	// watchdog well beyond the few thousand cycles the tests take
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		end_of_test();
	end

	initial begin
		seed = 32'h5a4a;
		{resetn, reg_wr, reg_rd, mode_level, bus_swap_sel} = '0;
		{sample_clk_first, sample_clk_second, core_over_first, core_over_second} = '0;
		{core_word_first, core_word_second, reg_addr, reg_wdata} = '0;
		{power_down_chan_first, power_down_chan_second} = '0;
		{output_enable_n_chan_first, output_enable_n_chan_second} = '0;
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		chk_reg(8'h00, 32'he7, 32'h0);
		chk_reg(8'h04, '1, 32'd50);
		chk_reg(8'h08, '1, 32'h64);
		wr(8'h08, 32'h5);
		chk_reg(8'h08, '1, 32'h5);
		chk_reg(8'h0c, '1, 32'h0);
		// stabilizer off, format flips between words, swap both ways
		for (int i = 0; i < 24; i++) begin
			bus_swap_sel <= (i < 12);
			sample((i % 2) ? 0 : 3, 1'b1);
		end
		// stabilizer on, checked once locked
		for (int i = 0; i < 120; i++) sample((i < 110) ? 1 : 2, i >= 105);
		// enable follows the channel the bus carries
		output_enable_n_chan_first <= 1'b1; // held for long spells only
		repeat (3) @(posedge sys_clk);
		#1 chk_oe(2'b10);
		bus_swap_sel <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk_oe(2'b01);
		// nap, then sleep, then sleep recovery on channel A only
		output_enable_n_chan_first <= 1'b0;
		power_down_chan_first <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk_oe(2'b01);
		chk_reg(8'h00, 32'he7, 32'h1);
		output_enable_n_chan_first <= 1'b1;
		chk_reg(8'h00, 32'he7, 32'h2);
		chk_oe(2'b01);
		output_enable_n_chan_first <= 1'b0;
		power_down_chan_first <= 1'b0;
		chk_reg(8'h00, 32'h7, 32'h4);
		repeat (60) @(posedge sys_clk);
		chk_reg(8'h00, 32'he7, 32'h0);
		// nap recovery counts sample edges
		power_down_chan_first <= 1'b1;
		chk_reg(8'h00, 32'h7, 32'h1);
		power_down_chan_first <= 1'b0;
		repeat (3) sample(2, 1'b0);
		chk_reg(8'h00, 32'h7, 32'h3);
		repeat (4) sample(2, 1'b0);
		chk_reg(8'h00, 32'h7, 32'h0);
		sample(2, 1'b0);
		sample(2, 1'b1);
		// one shared bus: swap select rides on the sample clocks
		sample(3, 1'b0, 1'b1);
		sample(3, 1'b1, 1'b1);
		end_of_test();
	end
endmodule : dadc_out_ctrl_test

`default_nettype wire
